// [rtl/dac_path_defs.svh]
// register offsets, field positions and reset values of the dac path
`ifndef DAC_PATH_DEFS_SVH
`define DAC_PATH_DEFS_SVH
`define OFS_CTRL       8'h00
`define OFS_ATT_L      8'h04
`define OFS_ATT_R      8'h08
`define OFS_PEAK_L     8'h0C
`define OFS_PEAK_R     8'h10
`define OFS_STATUS     8'h14
`define CTRL_SEL_LSB   0
`define CTRL_DIV2_BIT  4
`define CTRL_I4X_BIT   5
`define CTRL_MUTEL_BIT 8
`define CTRL_MUTER_BIT 9
`define CTRL_RESET     32'h0000_0300
`define ATT_RESET      7'h00
`define GAIN_FRAC      16
`define ATT_STEPS      128
`endif

// [rtl/dac_path_pkg.sv]
// types shared by the dac digital path
`default_nettype none
package dac_path_pkg;
   typedef struct packed {
      logic signed [23:0] left;
      logic signed [23:0] right;
   } stereo_t;
   typedef enum logic [2:0] {
      sel_playback,
      sel_aux,
      sel_rate_converter_source,
      sel_adc,
      sel_receiver
   } source_t;
endpackage
`default_nettype wire

// [rtl/stereo_dac_digital_path.sv]
// dac digital path: source mux, attenuators, mute, peak meters, clocking
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`include "dac_path_defs.svh"
`default_nettype none
module stereo_dac_digital_path #(
   parameter int NSRC = 5
) (
   input  wire  logic                 clk,
   input  wire  logic                 arst_n,
   input  wire  logic                 wb_cyc_i,
   input  wire  logic                 wb_stb_i,
   input  wire  logic                 wb_we_i,
   input  wire  logic [7:0]           wb_adr_i,
   input  wire  logic [3:0]           wb_sel_i,
   input  wire  logic [31:0]          wb_dat_i,
   output var   logic [31:0]          wb_dat_o,
   output var   logic                 wb_ack_o,
   input  wire  logic [NSRC-1:0]      aud_valid,
   input  wire  dac_path_pkg::stereo_t aud_data [NSRC],
   output var   logic [NSRC-1:0]      aud_ready,
   output var   logic                 mod_valid,
   output var   dac_path_pkg::stereo_t mod_data,
   input  wire  logic                 mod_ready,
   output var   logic                 engine_tick,
   output var   logic                 interp_4x
);
   import dac_path_pkg::*;

   if (NSRC != 5)
   begin : g_chk
      $error("source count must be 5");
   end

   logic [31:0] ctrl_reg;
   logic [6:0]  att_l_reg;
   logic [6:0]  att_r_reg;
   logic [23:0] peak_l_reg;
   logic [23:0] peak_r_reg;
   logic [1:0]  cnt_reg;
   logic [1:0]  cnt_next;
   stereo_t     tail_reg;
   logic        phase_reg;
   logic        push;
   logic        pop;
   stereo_t     picked;
   stereo_t     scaled;
   logic        bus_req;
   logic        rd_peak_l;
   logic        rd_peak_r;

   // gain of the low four attenuator bits, 1.0 = 2^16; high bits shift 6 dB
   localparam logic [16:0] GAIN_TAB [16] = '{
      17'h10000, 17'h0F52F, 17'h0EAD3, 17'h0E0E7, 17'h0D766, 17'h0CE4C,
      17'h0C595, 17'h0BD3C, 17'h0B53C, 17'h0AD94, 17'h0A63E, 17'h09F39,
      17'h0987D, 17'h0920D, 17'h08BE1, 17'h085F9
   };

   function automatic logic signed [23:0] attenuate(
      input logic signed [23:0] s,
      input logic [6:0]         a,
      input logic               mute
   );
      logic signed [41:0] p;
      p = s * $signed({1'b0, GAIN_TAB[a[3:0]]});
      p = p >>> (`GAIN_FRAC + a[6:4]);
      attenuate = mute ? 24'sh000000 : p[23:0];
   endfunction

   function automatic logic [23:0] mag(input logic signed [23:0] s);
      mag = s[23] ? 24'(-s) : 24'(s);
   endfunction

   // data comes from whichever source was offered ready, so a select
   // change never drops a sample that a source saw accepted
   always_comb
   begin
      push   = |(aud_valid & aud_ready);
      picked = '0;
      for (int i = 0; i < NSRC; i++)
         if (aud_valid[i] && aud_ready[i])
            picked = aud_data[i];
   end

   assign scaled.left  = attenuate(picked.left, att_l_reg,
                                   ctrl_reg[`CTRL_MUTEL_BIT]);
   assign scaled.right = attenuate(picked.right, att_r_reg,
                                   ctrl_reg[`CTRL_MUTER_BIT]);
   assign pop = mod_valid && mod_ready;

   always_comb
   begin
      cnt_next = cnt_reg;
      if (push && !pop)
         cnt_next = cnt_reg + 2'd1;
      else if (pop && !push)
         cnt_next = cnt_reg - 2'd1;
   end

   // two-entry buffer; head sits in mod_data so the output is a flop
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg   <= 2'd0;
         mod_valid <= 1'b0;
         mod_data  <= '0;
         tail_reg  <= '0;
      end
      else
      begin
         cnt_reg   <= cnt_next;
         mod_valid <= cnt_next != 2'd0;
         if (pop)
            mod_data <= (cnt_reg == 2'd2) ? tail_reg : scaled;
         else if (push && cnt_reg == 2'd0)
            mod_data <= scaled;
         if (push && (cnt_reg == 2'd2 || (cnt_reg == 2'd1 && !pop)))
            tail_reg <= scaled;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         aud_ready <= '0;
      else
      begin
         aud_ready <= '0;
         if (cnt_next != 2'd2 && ctrl_reg[2:0] < 3'(NSRC))
            aud_ready[ctrl_reg[2:0]] <= 1'b1;
      end
   end

   // master clock divider and interpolation select for the engine
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase_reg   <= 1'b0;
         engine_tick <= 1'b0;
         interp_4x   <= 1'b0;
      end
      else
      begin
         phase_reg   <= ~phase_reg;
         engine_tick <= ctrl_reg[`CTRL_DIV2_BIT] ? phase_reg : 1'b1;
         interp_4x   <= ctrl_reg[`CTRL_I4X_BIT];
      end
   end

   assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd_peak_l = bus_req && !wb_we_i && wb_adr_i == `OFS_PEAK_L;
   assign rd_peak_r = bus_req && !wb_we_i && wb_adr_i == `OFS_PEAK_R;

   // peak meters; a new sample in the read cycle wins over the clear
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         peak_l_reg <= 24'h000000;
         peak_r_reg <= 24'h000000;
      end
      else
      begin
         if (push && (rd_peak_l || mag(scaled.left) > peak_l_reg))
            peak_l_reg <= mag(scaled.left);
         else if (rd_peak_l)
            peak_l_reg <= 24'h000000;
         if (push && (rd_peak_r || mag(scaled.right) > peak_r_reg))
            peak_r_reg <= mag(scaled.right);
         else if (rd_peak_r)
            peak_r_reg <= 24'h000000;
      end
   end

   // wishbone slave: one wait state, unmapped reads give zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= 32'h0000_0000;
         ctrl_reg  <= `CTRL_RESET;
         att_l_reg <= `ATT_RESET;
         att_r_reg <= `ATT_RESET;
      end
      else
      begin
         wb_ack_o <= bus_req;
         if (bus_req && wb_we_i)
         begin
            case (wb_adr_i)
               `OFS_CTRL:
               begin
                  if (wb_sel_i[0])
                     ctrl_reg[7:0] <= wb_dat_i[7:0] & 8'h37;
                  if (wb_sel_i[1])
                     ctrl_reg[15:8] <= wb_dat_i[15:8] & 8'h03;
               end
               `OFS_ATT_L:
                  if (wb_sel_i[0])
                     att_l_reg <= wb_dat_i[6:0];
               `OFS_ATT_R:
                  if (wb_sel_i[0])
                     att_r_reg <= wb_dat_i[6:0];
               default: ;
            endcase
         end
         if (bus_req && !wb_we_i)
         begin
            case (wb_adr_i)
               `OFS_CTRL:   wb_dat_o <= ctrl_reg;
               `OFS_ATT_L:  wb_dat_o <= {25'h0, att_l_reg};
               `OFS_ATT_R:  wb_dat_o <= {25'h0, att_r_reg};
               `OFS_PEAK_L: wb_dat_o <= {8'h00, peak_l_reg};
               `OFS_PEAK_R: wb_dat_o <= {8'h00, peak_r_reg};
               `OFS_STATUS: wb_dat_o <= {29'h0, phase_reg, cnt_reg};
               default:     wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   sequence s_peak_read;
      rd_peak_l && !push;
   endsequence

   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_mute_zero;
      @(posedge clk) disable iff (!arst_n)
      push && ctrl_reg[`CTRL_MUTEL_BIT] |-> scaled.left == 24'sh000000;
   endproperty
   a_mute_zero: assert property (p_mute_zero)
      else $error("muted left channel passed a nonzero sample");
   property p_source_sel;
      @(posedge clk) disable iff (!arst_n)
      push |-> (aud_valid & aud_ready) == (5'h01 << $past(ctrl_reg[2:0]));
   endproperty
   a_source_sel: assert property (p_source_sel)
      else $error("sample taken from a source not selected");
   property p_peak_clear;
      @(posedge clk) disable iff (!arst_n)
      s_peak_read |=> peak_l_reg == 24'h000000;
   endproperty
   a_peak_clear: assert property (p_peak_clear)
      else $error("left peak not cleared by read");
   property p_unity;
      @(posedge clk) disable iff (!arst_n)
      push && att_l_reg == 7'h00 && !ctrl_reg[`CTRL_MUTEL_BIT]
         |-> scaled.left == picked.left;
   endproperty
   a_unity: assert property (p_unity)
      else $error("zero attenuation altered the sample");
   property p_deep_att;
      @(posedge clk) disable iff (!arst_n)
      push && att_l_reg == 7'h7F
         |-> mag(scaled.left) <= (mag(picked.left) >> 7) + 24'h000001;
   endproperty
   a_deep_att: assert property (p_deep_att)
      else $error("full attenuation too weak");
   property p_div_half;
      @(posedge clk) disable iff (!arst_n)
      ctrl_reg[`CTRL_DIV2_BIT] [*3] ##0 engine_tick |=> !engine_tick;
   endproperty
   a_div_half: assert property (p_div_half)
      else $error("divided engine ticked two cycles running");
   property p_div_off;
      @(posedge clk) disable iff (!arst_n)
      !ctrl_reg[`CTRL_DIV2_BIT] [*2] |=> engine_tick;
   endproperty
   a_div_off: assert property (p_div_off)
      else $error("undivided engine missed a tick");
   property p_interp;
      @(posedge clk) disable iff (!arst_n)
      $changed(ctrl_reg[`CTRL_I4X_BIT]) |=> interp_4x == $past(ctrl_reg[5]);
   endproperty
   a_interp: assert property (p_interp)
      else $error("interpolation select did not follow control");
   property p_ack;
      @(posedge clk) disable iff (!arst_n)
      bus_req |=> s_ack_pulse;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus ack not a single cycle after request");
endmodule
`default_nettype wire

// [tb/audio_source_model.sv]
// behavioural model of the five audio sources feeding the dac path
`default_nettype none
module audio_source_model
   import dac_path_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       en,
   input  wire logic [4:0] aud_ready,
   output var  logic [4:0] aud_valid,
   output var  stereo_t    aud_data [5]
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] junk_reg;
   // a sample once offered is held until the path takes it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aud_valid <= 5'h00;
         junk_reg  <= 24'h000000;
      end
      else
      begin
         junk_reg  <= junk_reg + 24'h000001;
         aud_valid <= {5{en}} | (aud_valid & ~aud_ready);
      end
   end
   // idle sources show a changing pattern, never a stale sample
   always_comb
   begin
      for (int k = 0; k < 5; k++)
      begin
         aud_data[k].left  = aud_valid[k] ? 24'(24'h010000 * (k + 1))
                                          : junk_reg;
         aud_data[k].right = aud_valid[k] ? 24'(-24'h010000 * (k + 1))
                                          : ~junk_reg;
      end
   end
endmodule
`default_nettype wire

// [tb/stereo_dac_digital_path_bench.sv]
// self-checking bench of the dac digital path
`include "dac_path_defs.svh"
`default_nettype none
module stereo_dac_digital_path_bench;
   import dac_path_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        arst_n, cyc, stb, we, en, mod_ready, ack;
   logic        mod_valid, engine_tick, interp_4x, t0, t1;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, dat_o;
   logic [4:0]  aud_valid, aud_ready;
   stereo_t     aud_data [5];
   stereo_t     mod_data, smp;
   int          fail_count, n_compared, i;
   stereo_dac_digital_path dut_u (.clk(clk), .arst_n(arst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .aud_valid(aud_valid), .aud_data(aud_data), .aud_ready(aud_ready),
      .mod_valid(mod_valid), .mod_data(mod_data), .mod_ready(mod_ready),
      .engine_tick(engine_tick), .interp_4x(interp_4x));
   audio_source_model src_u (.clk(clk), .arst_n(arst_n), .en(en),
      .aud_ready(aud_ready), .aud_valid(aud_valid), .aud_data(aud_data));
   always #10 clk = ~clk;
   // level each source offers on its left channel; right is the negative
   function automatic logic [23:0] lvl(input int k);
      return 24'(24'h010000 * (k + 1));
   endfunction
   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n >= 20)
      begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      check(rdat, exp);
   endtask
   // count samples taken by the modulator, keeping the last one
   task automatic take(input int cnt);
      int n;
      n = 0;
      while (cnt > 0 && n < 200)
      begin
         @(posedge clk);
         n++;
         if (mod_valid === 1'b1 && mod_ready === 1'b1)
         begin
            smp = mod_data;
            cnt--;
         end
      end
      if (n >= 200)
      begin
         fail_count++;
         print_verdict();
      end
   endtask
   initial
   begin
      fail_count = 0;
      n_compared = 0;
      arst_n = 1'b0;
      {cyc, stb, we, en} = 4'h0;
      mod_ready = 1'b1;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0000_0000;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      rd(`OFS_CTRL, `CTRL_RESET);
      rd(`OFS_ATT_L, 32'h0000_0000);
      rd(`OFS_ATT_R, 32'h0000_0000);
      rd(`OFS_PEAK_L, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      @(negedge clk);
      check({31'h0, interp_4x}, 32'h0000_0000);
      check({31'h0, engine_tick}, 32'h0000_0001);
      en <= 1'b1;
      take(4);
      check({8'h00, smp.left}, 32'h0000_0000);
      check({8'h00, smp.right}, 32'h0000_0000);
      for (i = 0; i < 5; i++)
      begin
         wb(1'b1, `OFS_CTRL, i);
         take(6);
         check({8'h00, smp.left}, lvl(i));
         check({8'h00, smp.right}, {8'h00, -lvl(i)});
         check({27'h0, aud_ready}, 32'h1 << i);
      end
      wb(1'b1, `OFS_CTRL, 32'h0000_0005);
      en <= 1'b0;
      repeat (4) @(posedge clk);
      check({27'h0, aud_ready}, 32'h0000_0000);
      rd(`OFS_PEAK_L, lvl(4));
      rd(`OFS_PEAK_L, 32'h0000_0000);
      rd(`OFS_PEAK_R, lvl(4));
      wb(1'b1, `OFS_CTRL, 32'h0000_0004);
      wb(1'b1, `OFS_ATT_L, 32'h0000_0010);
      rd(`OFS_ATT_L, 32'h0000_0010);
      en <= 1'b1;
      take(6);
      check({8'h00, smp.right}, {8'h00, -lvl(4)});
      check({31'h0, smp.left > 0 && smp.left < lvl(4)}, 32'h1);
      mod_ready <= 1'b0;
      repeat (8) @(posedge clk);
      check({27'h0, aud_ready}, 32'h0000_0000);
      rd(`OFS_STATUS, 32'h0000_0002);
      mod_ready <= 1'b1;
      wb(1'b1, `OFS_CTRL, 32'h0000_0034);
      @(negedge clk);
      t0 = engine_tick;
      @(negedge clk);
      t1 = engine_tick;
      check({31'h0, t0 ^ t1}, 32'h0000_0001);
      check({31'h0, interp_4x}, 32'h0000_0001);
      take(3);
      // deepest setting: 47.6 dB lies between a 128 and a 256 fold cut
      wb(1'b1, `OFS_ATT_L, 32'h0000_007F);
      take(6);
      check({31'h0, smp.left > (lvl(4) >> 8)}, 32'h1);
      check({31'h0, smp.left < (lvl(4) >> 7)}, 32'h1);
      check({8'h00, smp.right}, {8'h00, -lvl(4)});
      print_verdict();
   end
endmodule
`default_nettype wire
